// ===== hdl/scd_pkg.sv
// package: constants and types of the run-mode clock divider block
package scd_pkg;
    // ======================================================
    // register offsets
    localparam logic [11:0] OFS_STAT = 12'h050;
    localparam logic [11:0] OFS_CFG = 12'h060;
    localparam logic [11:0] OFS_XLATE = 12'h064;
    localparam logic [11:0] OFS_CFG_EXT = 12'h070;
    localparam logic [11:0] OFS_GATE = 12'h108;
    localparam logic [11:0] OFS_DSLP = 12'h144;

    // ======================================================
    // field positions
    localparam int OSC_LSB = 4;
    localparam int CRYSTAL_SELECT_LSB = 6;
    localparam int BYP_BIT = 11;
    localparam int PD_BIT = 13;
    localparam int USE_BIT = 22;
    localparam int DIV_LSB = 23;
    localparam int OVR_BIT = 31;

    // ======================================================
    // reset values and writable-bit masks
    localparam logic [31:0] CFG_RST = 32'h0780_2ac0;
    localparam logic [31:0] CFG_MASK = 32'h07c0_3ff0;
    localparam logic [31:0] EXT_RST = 32'h0780_2800;
    localparam logic [31:0] EXT_MASK = 32'h9f80_2830;
    localparam logic [31:0] DSLP_RST = 32'h0000_0000;
    localparam logic [31:0] DSLP_MASK = 32'h1f80_0030;
    localparam logic [13:0] XLATE_RST = 14'h056b;
    localparam logic [8:0] XLATE_F_BASE = 9'h020;
    localparam logic [6:0] DIV_RST = 7'h01;

    // ======================================================
    // divisor encodings and relock count
    localparam logic [5:0] RSV_MAX = 6'h06;
    localparam logic [5:0] RSV_ODD = 6'h08;
    localparam logic [5:0] RSV_EXT_MAX = 6'h08;
    localparam logic [15:0] RELOCK_LOAD = 16'h1200;

    // ======================================================
    // types
    // one core_clk wide tick of each raw source, by source code
    typedef struct packed {
        logic slow_osc;
        logic int_div4;
        logic int_osc;
        logic main_oscillator;
    } scd_osc_type;

    typedef struct packed {
        logic bypass;
        logic pwr_down;
        logic divider_in_use;
        logic [1:0] osc;
        logic [5:0] sys_divisor;
    } scd_sel_type;

    typedef enum logic [1:0] {
        PLL_OFF,
        PLL_LOCK,
        PLL_RUN
    } scd_pll_state_type;
endpackage

// ===== hdl/scd_clock_ctrl.sv
// run-mode system clock divider, pll control and register port
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps

// ======================================================
// Summary of operation
// - override bit set makes extended register fields replace primary ones.
// - divisor field divides pll clock or raw source, chosen by bypass.
// - pll path halves the vco ticks before the system divisor.
// - four-bit divisor field gives divisor of encoding plus one.
// - pll path encodings 0 to 6 and 8 reserved; flagged in status.
// - bypass with divider in use and encoding zero still divides the source by two.
// - extended divisor field is six bits, reaching divide by 64.
// - six-bit extended divisor gives divisor of encoding plus one.
// - extended pll path encodings 0 to 8 reserved; flagged in status.
// - divider unused and pll off delivers the source undivided.
// - crystal code is translated into pll settings.
// - translation register returns the hardware pll settings.
// - each crystal code write recomputes the translation.
// - pll stays powered down after reset until software enables it.
// - pll has normal and power-down modes; power-down stops output.
// - system ticks feed peripherals, each with its own enable.
// - deep sleep takes source and divisor from deep-sleep register.
// - pll power-up or reconfig loads relock counter, counted by main osc.
// - rewriting the same crystal code causes no relock.
// - pll selected early keeps the raw source until relock ends.
module scd_clock_ctrl #(
    parameter int NUM_PERIPH = 8,
    parameter logic [15:0] RELOCK_LOAD = scd_pkg::RELOCK_LOAD
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // source ticks and power mode
    input wire scd_pkg::scd_osc_type osc_tick,
    input wire logic vco_tick,
    input wire logic deep_sleep,
    // pll control
    output logic pll_power_down,
    output logic pll_drive,
    output logic pll_locked,
    output logic [13:0] pll_setting,
    // system clock
    output logic sys_tick,
    output logic [NUM_PERIPH-1:0] periph_tick
);
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_bad_periph
        $error("NUM_PERIPH must lie between 1 and 32");
    end
    if (RELOCK_LOAD == 16'h0000) begin : g_bad_relock
        $error("RELOCK_LOAD must not be zero");
    end

    // ======================================================
    // functions
    // arbitrary but fixed crystal to pll mapping: {feedback, ref code}
    function automatic logic [13:0] xlate(input logic [4:0] crystal_select);
        xlate = {scd_pkg::XLATE_F_BASE + {4'h0, crystal_select}, crystal_select};
    endfunction

    function automatic logic [6:0] eff_div(input logic [5:0] enc,
                                           input logic raw,
                                           input logic use_div);
        if (!use_div) begin
            eff_div = 7'h01;
        end else if (raw && enc == 6'h00) begin
            eff_div = 7'h02;
        end else begin
            eff_div = {1'b0, enc} + 7'h01;
        end
    endfunction

    // ======================================================
    // registers
    logic [31:0] cfg_reg;
    logic [31:0] ext_reg;
    logic [31:0] dslp_reg;
    logic [NUM_PERIPH-1:0] gate_reg;
    logic [13:0] xlate_reg;
    logic [31:0] rdata_reg;
    logic [15:0] relock_reg;
    logic [15:0] relock_next;
    scd_pkg::scd_pll_state_type state_reg;
    scd_pkg::scd_pll_state_type state_next;
    logic vco_half_reg;
    logic cur_pll_reg;
    logic [1:0] cur_osc_reg;
    logic [6:0] div_reg;
    logic [6:0] cnt_reg;
    logic sys_tick_reg;
    logic [NUM_PERIPH-1:0] periph_tick_reg;

    // ======================================================
    // write decode
    wire logic cfg_wr = reg_wr && reg_addr == scd_pkg::OFS_CFG;
    wire logic ext_wr = reg_wr && reg_addr == scd_pkg::OFS_CFG_EXT;
    wire logic dslp_wr = reg_wr && reg_addr == scd_pkg::OFS_DSLP;
    wire logic gate_wr = reg_wr && reg_addr == scd_pkg::OFS_GATE;
    wire logic [4:0] crystal_select_old = cfg_reg[scd_pkg::CRYSTAL_SELECT_LSB +: 5];
    wire logic [4:0] crystal_select_new = reg_wdata[scd_pkg::CRYSTAL_SELECT_LSB +: 5];
    // same-value writes must not disturb a locked pll
    wire logic crystal_select_chg = cfg_wr && crystal_select_new != crystal_select_old;

    // ======================================================
    // effective selection
    wire logic ovr = ext_reg[scd_pkg::OVR_BIT];
    scd_pkg::scd_sel_type pri_sel;
    scd_pkg::scd_sel_type ext_sel;
    scd_pkg::scd_sel_type run_sel;
    scd_pkg::scd_sel_type eff_sel;
    assign pri_sel = {cfg_reg[scd_pkg::BYP_BIT], cfg_reg[scd_pkg::PD_BIT],
                      cfg_reg[scd_pkg::USE_BIT],
                      cfg_reg[scd_pkg::OSC_LSB +: 2],
                      2'b00, cfg_reg[scd_pkg::DIV_LSB +: 4]};
    // extended divisor has no use bit of its own: always applied
    assign ext_sel = {ext_reg[scd_pkg::BYP_BIT], ext_reg[scd_pkg::PD_BIT],
                      1'b1, ext_reg[scd_pkg::OSC_LSB +: 2],
                      ext_reg[scd_pkg::DIV_LSB +: 6]};
    assign run_sel = ovr ? ext_sel : pri_sel;
    // deep sleep forces raw source and powers the pll down
    assign eff_sel = deep_sleep ?
                     {1'b1, 1'b1, 1'b1, dslp_reg[scd_pkg::OSC_LSB +: 2],
                      dslp_reg[scd_pkg::DIV_LSB +: 6]} : run_sel;
    wire logic pll_on = !eff_sel.pwr_down;

    // reserved pll divisors still divide; software is warned only
    wire logic rsv_pri = pri_sel.sys_divisor <= scd_pkg::RSV_MAX
                      || pri_sel.sys_divisor == scd_pkg::RSV_ODD;
    wire logic rsv_ext =
        ext_sel.sys_divisor <= scd_pkg::RSV_EXT_MAX;
    wire logic rsv_flag = !run_sel.bypass && (ovr ? rsv_ext : rsv_pri);

    // ======================================================
    // pll mode and relock counter
    always_comb begin
        state_next = state_reg;
        relock_next = relock_reg;
        unique case (state_reg)
            scd_pkg::PLL_OFF: begin
                if (pll_on) begin
                    state_next = scd_pkg::PLL_LOCK;
                    relock_next = RELOCK_LOAD;
                end
            end
            scd_pkg::PLL_LOCK: begin
                if (!pll_on) begin
                    state_next = scd_pkg::PLL_OFF;
                end else if (crystal_select_chg) begin
                    relock_next = RELOCK_LOAD;
                end else if (relock_reg == 16'h0000) begin
                    state_next = scd_pkg::PLL_RUN;
                end else if (osc_tick.main_oscillator) begin
                    relock_next = relock_reg - 16'h0001;
                end
            end
            scd_pkg::PLL_RUN: begin
                if (!pll_on) begin
                    state_next = scd_pkg::PLL_OFF;
                end else if (crystal_select_chg) begin
                    state_next = scd_pkg::PLL_LOCK;
                    relock_next = RELOCK_LOAD;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= scd_pkg::PLL_OFF;
            relock_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            relock_reg <= relock_next;
        end
    end

    assign pll_power_down = state_reg == scd_pkg::PLL_OFF;
    assign pll_drive = !pll_power_down;
    assign pll_locked = state_reg == scd_pkg::PLL_RUN;

    // ======================================================
    // divider
    // every second vco tick stands for the halved vco
    wire logic pll_tick = vco_tick && vco_half_reg;
    wire logic [3:0] osc_vec = osc_tick;
    wire logic want_pll = !eff_sel.bypass && pll_locked;
    wire logic [6:0] div_next = eff_div(eff_sel.sys_divisor, !want_pll,
                                        eff_sel.divider_in_use
                                        || want_pll);
    wire logic in_tick = cur_pll_reg ? pll_tick : osc_vec[cur_osc_reg];
    wire logic period_end = in_tick && cnt_reg == div_reg - 7'h01;
    // a dead pll emits no ticks, so leaving it at once makes no runt
    wire logic src_lost = cur_pll_reg && !pll_locked;
    wire logic reload = period_end || src_lost;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vco_half_reg <= 1'b0;
            cur_pll_reg <= 1'b0;
            cur_osc_reg <= 2'b00;
            div_reg <= scd_pkg::DIV_RST;
            cnt_reg <= 7'h00;
        end else begin
            if (vco_tick) begin
                vco_half_reg <= !vco_half_reg;
            end
            if (reload) begin
                cur_pll_reg <= want_pll;
                cur_osc_reg <= eff_sel.osc;
                div_reg <= div_next;
                cnt_reg <= 7'h00;
            end else if (in_tick) begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_tick_reg <= 1'b0;
            periph_tick_reg <= '0;
        end else begin
            sys_tick_reg <= period_end;
            periph_tick_reg <= {NUM_PERIPH{period_end}} & gate_reg;
        end
    end

    assign sys_tick = sys_tick_reg;
    assign periph_tick = periph_tick_reg;

    // ======================================================
    // register file
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= scd_pkg::CFG_RST;
            ext_reg <= scd_pkg::EXT_RST;
            dslp_reg <= scd_pkg::DSLP_RST;
            gate_reg <= '1;
            xlate_reg <= scd_pkg::XLATE_RST;
        end else begin
            if (cfg_wr) begin
                cfg_reg <= reg_wdata & scd_pkg::CFG_MASK;
                xlate_reg <= xlate(crystal_select_new);
            end
            if (ext_wr) begin
                ext_reg <= reg_wdata & scd_pkg::EXT_MASK;
            end
            if (dslp_wr) begin
                dslp_reg <= reg_wdata & scd_pkg::DSLP_MASK;
            end
            if (gate_wr) begin
                gate_reg <= reg_wdata[NUM_PERIPH-1:0];
            end
        end
    end

    assign pll_setting = xlate_reg;

    wire logic [31:0] stat_word = {relock_reg, 11'h000, rsv_flag,
                                   cur_pll_reg, pll_locked,
                                   pll_power_down, deep_sleep};
    wire logic [31:0] rd_mux =
        reg_addr == scd_pkg::OFS_CFG ? cfg_reg :
        reg_addr == scd_pkg::OFS_CFG_EXT ? ext_reg :
        reg_addr == scd_pkg::OFS_XLATE ? {18'h00000, xlate_reg} :
        reg_addr == scd_pkg::OFS_DSLP ? dslp_reg :
        reg_addr == scd_pkg::OFS_GATE ? 32'(gate_reg) :
        reg_addr == scd_pkg::OFS_STAT ? stat_word : 32'h0000_0000;

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

    // ======================================================
    // assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_xlate_follow;
        cfg_wr |=> xlate_reg == xlate($past(crystal_select_new));
    endproperty
    a_xlate_follow: assert property (p_xlate_follow)
        else $error("translation did not follow crystal write");
    property p_xlate_read;
        reg_rd && reg_addr == scd_pkg::OFS_XLATE
            |=> reg_rdata == {18'h00000, pll_setting};
    endproperty
    a_xlate_read: assert property (p_xlate_read)
        else $error("translation read returned wrong value");
    property p_relock_load;
        state_reg == scd_pkg::PLL_OFF && pll_on
            |=> state_reg == scd_pkg::PLL_LOCK && relock_reg == RELOCK_LOAD;
    endproperty
    a_relock_load: assert property (p_relock_load)
        else $error("relock counter not loaded at pll power-up");
    property p_same_crystal_select;
        cfg_wr && !crystal_select_chg && pll_locked && !ovr && !deep_sleep
            && !reg_wdata[scd_pkg::PD_BIT] |=> pll_locked;
    endproperty
    a_same_crystal_select: assert property (p_same_crystal_select)
        else $error("same crystal write caused relock");
    property p_no_early_pll;
        !pll_locked |=> !cur_pll_reg;
    endproperty
    a_no_early_pll: assert property (p_no_early_pll)
        else $error("pll used as clock before relock");
    property p_bypass_div0;
        reload && !want_pll && eff_sel.divider_in_use
            && eff_sel.sys_divisor == 6'h00 |=> div_reg == 7'h02;
    endproperty
    a_bypass_div0: assert property (p_bypass_div0)
        else $error("raw source encoding zero not divided by two");
    property p_div_plus1;
        reload && eff_sel.divider_in_use && eff_sel.sys_divisor != 6'h00
            |=> div_reg == {1'b0, $past(eff_sel.sys_divisor)} + 7'h01;
    endproperty
    a_div_plus1: assert property (p_div_plus1)
        else $error("divisor differs from encoding plus one");
    property p_undivided;
        reload && !eff_sel.divider_in_use && !want_pll |=> div_reg == 7'h01;
    endproperty
    a_undivided: assert property (p_undivided)
        else $error("source not passed undivided");
    property p_glitch_free;
        $changed(div_reg) || $changed(cur_pll_reg) |-> $past(reload);
    endproperty
    a_glitch_free: assert property (p_glitch_free)
        else $error("divider changed inside a period");
    property p_pd_output;
        pll_power_down |-> !pll_drive && !pll_locked ##1 !cur_pll_reg;
    endproperty
    a_pd_output: assert property (p_pd_output)
        else $error("powered-down pll still drives or clocks");
    // a continuous vco tick stream must still give pll ticks apart
    property p_half_vco;
        cur_pll_reg && in_tick ##1 cur_pll_reg |-> !in_tick;
    endproperty
    a_half_vco: assert property (p_half_vco)
        else $error("pll tick not halved");
    property p_periph_gate;
        period_end |=> periph_tick == $past(gate_reg) && sys_tick;
    endproperty
    a_periph_gate: assert property (p_periph_gate)
        else $error("peripheral tick not gated by its enable");
    property p_cov_lock;
        state_reg == scd_pkg::PLL_LOCK ##1 state_reg == scd_pkg::PLL_RUN;
    endproperty
    c_cov_lock: cover property (p_cov_lock);
    property p_cov_pll_tick;
        cur_pll_reg && sys_tick;
    endproperty
    c_cov_pll_tick: cover property (p_cov_pll_tick);
    property p_cov_deep;
        deep_sleep && period_end;
    endproperty
    c_cov_deep: cover property (p_cov_deep);
endmodule

// ===== bench/tb.sv
// self-checking bench of the run-mode clock divider block
`timescale 1ns/100ps

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module tb;
    // ======================================================
    // signals
    logic core_clk;
    logic sys_rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    scd_pkg::scd_osc_type osc_tick;
    logic vco_tick;
    logic deep_sleep;
    logic pll_power_down;
    logic pll_drive;
    logic pll_locked;
    logic [13:0] pll_setting;
    logic sys_tick;
    logic [7:0] periph_tick;
    int mismatches;
    int num_checks;
    int cyc;
    int per;
    logic [7:0] pt;
    logic [31:0] rv;
    int c0;

    // relock shortened so the run stays short
    scd_clock_ctrl #(.NUM_PERIPH(8), .RELOCK_LOAD(16'h0040)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_tick(osc_tick), .vco_tick(vco_tick),
        .deep_sleep(deep_sleep), .pll_power_down(pll_power_down),
        .pll_drive(pll_drive), .pll_locked(pll_locked),
        .pll_setting(pll_setting), .sys_tick(sys_tick),
        .periph_tick(periph_tick)
    );

    // ======================================================
    // clock, source ticks and timeout
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // distinct rates per source, so a wrong source shows as a wrong period
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        osc_tick.main_oscillator <= (cyc % 4 == 3);
        osc_tick.int_osc <= (cyc % 3 == 2);
        osc_tick.int_div4 <= (cyc % 5 == 4);
        osc_tick.slow_osc <= (cyc % 7 == 6);
        vco_tick <= 1'b1;
        if (cyc == 30000) begin
            mismatches++;
            $display("unexpected at %0t: run hung", $time);
            end_sim();
        end
    end

    // ======================================================
    // helpers
    function automatic logic [31:0] cfg(logic [1:0] osc, logic [4:0] xt,
        logic byp, logic pd, logic use_d, logic [3:0] dv);
        cfg = ({30'h0, osc} << scd_pkg::OSC_LSB)
            | ({27'h0, xt} << scd_pkg::CRYSTAL_SELECT_LSB)
            | ({31'h0, byp} << scd_pkg::BYP_BIT)
            | ({31'h0, pd} << scd_pkg::PD_BIT)
            | ({31'h0, use_d} << scd_pkg::USE_BIT)
            | ({28'h0, dv} << scd_pkg::DIV_LSB);
    endfunction

    function automatic logic [31:0] ext(logic ovr, logic [5:0] dv,
        logic pd, logic byp, logic [1:0] osc);
        ext = ({31'h0, ovr} << scd_pkg::OVR_BIT)
            | ({26'h0, dv} << scd_pkg::DIV_LSB)
            | ({31'h0, pd} << scd_pkg::PD_BIT)
            | ({31'h0, byp} << scd_pkg::BYP_BIT)
            | ({30'h0, osc} << scd_pkg::OSC_LSB);
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

    // first two intervals may still run on the old setting, so they are dropped
    task automatic measure(output int p);
        int n;
        int k;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (sys_tick !== 1'b1 && n < 2000);
        end
        pt = periph_tick;
        p = n;
    endtask

    task automatic wait_lock();
        int n;
        n = 0;
        while (pll_locked !== 1'b1 && n < 600) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // ======================================================
    // scenarios
    task automatic t_reset();
        `CHK(pll_power_down, 1'b1)
        `CHK(pll_drive, 1'b0)
        `CHK(pll_locked, 1'b0)
        rd(scd_pkg::OFS_CFG, rv);
        `CHK(rv, scd_pkg::CFG_RST)
        rd(scd_pkg::OFS_CFG_EXT, rv);
        `CHK(rv, scd_pkg::EXT_RST)
        rd(scd_pkg::OFS_XLATE, rv);
        `CHK(rv, {18'h0, scd_pkg::XLATE_RST})
        rd(scd_pkg::OFS_GATE, rv);
        `CHK(rv, 32'h0000_00ff)
        rd(12'h0fc, rv);
        `CHK(rv, 32'h0000_0000)
        measure(per);
        `CHK(per, 4)
        $display("test reset done");
    endtask

    task automatic t_raw();
        int src;
        int rate[4] = '{4, 3, 5, 7};
        for (src = 0; src < 4; src++) begin
            wr(scd_pkg::OFS_CFG, cfg(src[1:0], 5'h0b, 1'b1, 1'b1, 1'b1,
                4'h1));
            measure(per);
            `CHK(per, 2 * rate[src])
        end
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h0b, 1'b1, 1'b1, 1'b1, 4'h0));
        measure(per);
        `CHK(per, 8)
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h0b, 1'b1, 1'b1, 1'b1, 4'h4));
        measure(per);
        `CHK(per, 20)
        $display("test raw divider done");
    endtask

    task automatic t_ext();
        wr(scd_pkg::OFS_CFG_EXT, ext(1'b1, 6'h3f, 1'b1, 1'b1, 2'h0));
        measure(per);
        `CHK(per, 256)
        wr(scd_pkg::OFS_CFG_EXT, ext(1'b1, 6'h10, 1'b1, 1'b1, 2'h0));
        measure(per);
        `CHK(per, 68)
        wr(scd_pkg::OFS_CFG_EXT, ext(1'b1, 6'h08, 1'b1, 1'b0, 2'h0));
        rd(scd_pkg::OFS_STAT, rv);
        `CHK(rv[4], 1'b1)
        wr(scd_pkg::OFS_CFG_EXT, ext(1'b1, 6'h09, 1'b1, 1'b0, 2'h0));
        rd(scd_pkg::OFS_STAT, rv);
        `CHK(rv[4], 1'b0)
        wr(scd_pkg::OFS_CFG_EXT, 32'h0);
        $display("test extended divider done");
    endtask

    task automatic t_pll();
        // crystal codes kept inside the pll reference range
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h0b, 1'b0, 1'b0, 1'b1, 4'h7));
        c0 = cyc;
        repeat (2) @(posedge core_clk);
        `CHK({pll_power_down, pll_drive, pll_locked}, 3'b010)
        measure(per);
        `CHK(per, 32)
        wait_lock();
        `CHK((cyc - c0 >= 252) && (cyc - c0 <= 268), 1'b1)
        measure(per);
        `CHK(per, 16)
        rd(scd_pkg::OFS_STAT, rv);
        `CHK(rv[4:0], 5'h0c)
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h0b, 1'b0, 1'b0, 1'b1, 4'h7));
        repeat (4) @(posedge core_clk);
        `CHK(pll_locked, 1'b1)
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h10, 1'b0, 1'b0, 1'b1, 4'hf));
        repeat (2) @(posedge core_clk);
        `CHK(pll_setting, {9'h030, 5'h10})
        `CHK(pll_locked, 1'b0)
        rd(scd_pkg::OFS_XLATE, rv);
        `CHK(rv, {18'h0, 9'h030, 5'h10})
        wait_lock();
        measure(per);
        `CHK(per, 32)
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h10, 1'b0, 1'b0, 1'b1, 4'h8));
        rd(scd_pkg::OFS_STAT, rv);
        `CHK(rv[4], 1'b1)
        wr(scd_pkg::OFS_CFG, cfg(2'h0, 5'h10, 1'b1, 1'b1, 1'b1, 4'h1));
        repeat (2) @(posedge core_clk);
        `CHK({pll_power_down, pll_drive, pll_locked}, 3'b100)
        $display("test pll done");
    endtask

    task automatic t_dslp_gate();
        wr(scd_pkg::OFS_DSLP, ext(1'b0, 6'h03, 1'b0, 1'b0, 2'h0));
        wr(scd_pkg::OFS_GATE, 32'h0000_0005);
        @(posedge core_clk);
        deep_sleep <= 1'b1;
        measure(per);
        `CHK(per, 16)
        `CHK(pt, 8'h05)
        rd(scd_pkg::OFS_STAT, rv);
        `CHK(rv[1:0], 2'b11)
        @(posedge core_clk);
        deep_sleep <= 1'b0;
        measure(per);
        `CHK(per, 8)
        $display("test deep sleep and gating done");
    endtask

    // ======================================================
    // closing report
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        mismatches = 0;
        num_checks = 0;
        cyc = 0;
        sys_rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        osc_tick = '0;
        vco_tick = 1'b0;
        deep_sleep = 1'b0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_raw();
        t_ext();
        t_pll();
        t_dslp_gate();
        end_sim();
    end
endmodule
